/* File: hdl/pwtc_map.vh */
`ifndef PWTC_MAP_VH
`define PWTC_MAP_VH
// Register indices (word addresses on the plain port)
`define PWTC_ADDR_CONTROL   4'h0
`define PWTC_ADDR_COUNT_LOW 4'h1
`define PWTC_ADDR_COUNT_HI  4'h2
`define PWTC_ADDR_IRQ_CTRL  4'h3
`define PWTC_ADDR_STATUS    4'h4
// Control register fields
`define PWTC_MODE_HI_BIT    7
`define PWTC_MODE_LO_BIT    6
`define PWTC_RUN_BIT        4
`define PWTC_EDGE_BIT       3
// Mode select encodings
`define PWTC_MODE_TIMER     2'h2
`define PWTC_MODE_EVENT     2'h1
`define PWTC_MODE_PULSE     2'h3
// Interrupt control fields
`define PWTC_IRQ_EN_BIT     0
`define PWTC_IRQ_FLAG_BIT   1
// Reset values and counter full value
`define PWTC_CONTROL_RESET  8'h00
`define PWTC_IRQ_RESET      8'h00
`define PWTC_COUNT_RESET    16'h0000
`define PWTC_COUNT_FULL     16'hFFFF
// Instruction clock divide
`define PWTC_CLK_DIV        2'h3
`endif

/* File: hdl/pwtc_input_sync.v */
`timescale 1ns/100ps
// Two-stage synchroniser with edge detection on the tick-sampled level
module pwtc_input_sync (
    input  wire core_clk,
    input  wire reset,
    input  wire tick,
    input  wire pinIn,
    output reg  level,
    output wire rise,
    output wire fall
);
    reg stageOne;
    reg stageTwo;
    reg prevLevel;

    // Pin sampled into the two stages every clock
    always @(posedge core_clk) begin
        if (reset) begin
            stageOne <= 1'b0;
            stageTwo <= 1'b0;
        end else begin
            stageOne <= pinIn;
            stageTwo <= stageOne;
        end
    end

    // Events only take effect on the timer clock pulse
    always @(posedge core_clk) begin
        if (reset) begin
            level     <= 1'b0;
            prevLevel <= 1'b0;
        end else if (tick) begin
            level     <= stageTwo;
            prevLevel <= level;
        end
    end

    // Edge seen between current and previous sample
    assign rise = level & ~prevLevel;
    assign fall = ~level & prevLevel;
endmodule

/* File: hdl/pwtc_prescaler.v */
`timescale 1ns/100ps
`include "pwtc_map.vh"
// Instruction clock tick, one core_clk cycle in four
module pwtc_prescaler (
    input  wire core_clk,
    input  wire reset,
    output reg  tick
);
    reg [1:0] divCount;

    // Free-running divide by four
    always @(posedge core_clk) begin
        if (reset) begin
            divCount <= 2'h0;
            tick     <= 1'b0;
        end else begin
            divCount <= divCount + 2'h1;
            tick     <= (divCount == `PWTC_CLK_DIV);
        end
    end
endmodule

/* File: hdl/pwtc_timer.v */
`timescale 1ns/100ps
`include "pwtc_map.vh"
module pwtc_timer (
    input  wire       core_clk,
    input  wire       reset,
    input  wire [3:0] regAddr,
    input  wire [7:0] regWriteData,
    input  wire       regWrite,
    input  wire       regRead,
    output reg  [7:0] regReadData,
    input  wire       ch0InputPin,
    input  wire       powerDown,
    output reg        timerIrq,
    output reg        wakeUp,
    output reg        overflowPulse
);
    localparam ST_IDLE  = 3'b001;
    localparam ST_ARMED = 3'b010;
    localparam ST_COUNT = 3'b100;

    reg  [7:0]  ch0ControlReg;
    reg  [7:0]  irqControlReg;
    reg  [15:0] counter;
    reg  [15:0] preload;
    reg  [7:0]  lowWriteBuf;
    reg  [7:0]  lowReadBuf;
    reg  [2:0]  pulseState;
    reg  [2:0]  next_pulseState;
    reg         countNow;
    reg         autoStop;
    wire        tick;
    wire        pinLevel;
    wire        pinRise;
    wire        pinFall;
    wire [1:0]  modeSel;
    wire        runEnable;
    wire        edgeSel;
    wire        pulseMode;
    wire        eventMode;
    wire        timerMode;
    wire        accessHold;
    wire        startEdge;
    wire        stopEdge;
    wire        eventEdge;
    wire        overflow;
    wire        writeCtrl;
    wire        writeLow;
    wire        writeHigh;
    wire        writeIrq;
    wire [15:0] newPreload;

    pwtc_prescaler u_prescaler (
        .core_clk (core_clk),
        .reset    (reset),
        .tick     (tick)
    );

    pwtc_input_sync u_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .tick     (tick),
        .pinIn    (ch0InputPin),
        .level    (pinLevel),
        .rise     (pinRise),
        .fall     (pinFall)
    );

    // Field decode of the control register
    assign modeSel   = {ch0ControlReg[`PWTC_MODE_HI_BIT], ch0ControlReg[`PWTC_MODE_LO_BIT]};
    assign runEnable = ch0ControlReg[`PWTC_RUN_BIT];
    assign edgeSel   = ch0ControlReg[`PWTC_EDGE_BIT];
    assign pulseMode = (modeSel == `PWTC_MODE_PULSE);
    assign eventMode = (modeSel == `PWTC_MODE_EVENT);
    assign timerMode = (modeSel == `PWTC_MODE_TIMER);

    // Register strobes
    assign writeCtrl = regWrite & (regAddr == `PWTC_ADDR_CONTROL);
    assign writeLow  = regWrite & (regAddr == `PWTC_ADDR_COUNT_LOW);
    assign writeHigh = regWrite & (regAddr == `PWTC_ADDR_COUNT_HI);
    assign writeIrq  = regWrite & (regAddr == `PWTC_ADDR_IRQ_CTRL);
    assign newPreload = {regWriteData, lowWriteBuf};

    // Counting clock held off while software touches the counter
    assign accessHold = writeLow | writeHigh
                      | (regRead & ((regAddr == `PWTC_ADDR_COUNT_LOW)
                      | (regAddr == `PWTC_ADDR_COUNT_HI)));

    // Active edges chosen by edge select
    assign startEdge = edgeSel ? pinRise : pinFall;
    assign stopEdge  = edgeSel ? pinFall : pinRise;
    assign eventEdge = edgeSel ? pinFall : pinRise;

    // Pulse measurement sequence
    always @* begin
        next_pulseState = pulseState;
        autoStop        = 1'b0;
        case (pulseState)
            ST_IDLE: begin
                if (pulseMode && runEnable)
                    next_pulseState = ST_ARMED;
            end
            ST_ARMED: begin
                if (!(pulseMode && runEnable))
                    next_pulseState = ST_IDLE;
                else if (tick && startEdge)
                    next_pulseState = ST_COUNT;
            end
            ST_COUNT: begin
                if (!(pulseMode && runEnable)) begin
                    next_pulseState = ST_IDLE;
                end else if (tick && stopEdge) begin
                    next_pulseState = ST_IDLE;
                    autoStop        = 1'b1;
                end
            end
            default: next_pulseState = ST_IDLE;
        endcase
    end

    // Counting qualifier per mode, power-down does not stop it
    always @* begin
        countNow = 1'b0;
        if (runEnable && tick && !accessHold) begin
            if (timerMode)
                countNow = 1'b1;
            else if (eventMode)
                countNow = eventEdge;
            else if (pulseMode)
                countNow = (pulseState == ST_COUNT) && !autoStop;
        end
    end

    assign overflow = countNow && (counter == `PWTC_COUNT_FULL);

    always @(posedge core_clk) begin
        if (reset)
            pulseState <= ST_IDLE;
        else
            pulseState <= next_pulseState;
    end

    // Control register, with self clear in pulse mode only
    always @(posedge core_clk) begin
        if (reset)
            ch0ControlReg <= `PWTC_CONTROL_RESET;
        else if (writeCtrl)
            ch0ControlReg <= regWriteData;
        else if (autoStop && pulseMode)
            ch0ControlReg[`PWTC_RUN_BIT] <= 1'b0;
    end

    // Counter, preload and low byte write buffer
    always @(posedge core_clk) begin
        if (reset) begin
            counter     <= `PWTC_COUNT_RESET;
            preload     <= `PWTC_COUNT_RESET;
            lowWriteBuf <= 8'h00;
        end else begin
            if (writeLow)
                lowWriteBuf <= regWriteData;
            if (writeHigh) begin
                preload <= newPreload;
                if (!runEnable)
                    counter <= newPreload;
            end else if (overflow) begin
                counter <= preload;
            end else if (countNow) begin
                counter <= counter + 16'h0001;
            end
        end
    end

    // Interrupt control: enable bit and sticky request flag
    always @(posedge core_clk) begin
        if (reset) begin
            irqControlReg <= `PWTC_IRQ_RESET;
        end else begin
            if (writeIrq)
                irqControlReg <= regWriteData;
            if (overflow)
                irqControlReg[`PWTC_IRQ_FLAG_BIT] <= 1'b1;
        end
    end

    // Interrupt, wake-up and overflow outputs
    always @(posedge core_clk) begin
        if (reset) begin
            timerIrq      <= 1'b0;
            wakeUp        <= 1'b0;
            overflowPulse <= 1'b0;
        end else begin
            overflowPulse <= overflow;
            timerIrq      <= overflow && irqControlReg[`PWTC_IRQ_EN_BIT];
            wakeUp        <= overflow && powerDown;
        end
    end

    // Read port, data in the cycle after the strobe
    always @(posedge core_clk) begin
        if (reset) begin
            regReadData <= 8'h00;
            lowReadBuf  <= 8'h00;
        end else begin
            regReadData <= 8'h00;
            if (regRead) begin
                case (regAddr)
                    `PWTC_ADDR_CONTROL:   regReadData <= ch0ControlReg;
                    `PWTC_ADDR_COUNT_LOW: regReadData <= lowReadBuf;
                    `PWTC_ADDR_COUNT_HI: begin
                        regReadData <= counter[15:8];
                        lowReadBuf  <= counter[7:0];
                    end
                    `PWTC_ADDR_IRQ_CTRL:  regReadData <= irqControlReg;
                    `PWTC_ADDR_STATUS:    regReadData <= {5'h00, pulseState == ST_COUNT,
                                                          pulseState == ST_ARMED, pinLevel};
                    default:              regReadData <= 8'h00;
                endcase
            end
        end
    end
endmodule

/* File: verif/pwtc_pin_source.sv */
`timescale 1ns/100ps
// Pulse source on the timer pin
module pwtc_pin_source (
    input  wire logic core_clk,
    output logic      pinOut
);
    logic idleLevel = 1'b1;
    initial pinOut = 1'b1;
    // Move to a new idle level and let it settle
    task setIdle(input logic lvl);
        idleLevel = lvl;
        pinOut <= lvl;
        repeat (8) @(posedge core_clk);
    endtask
    // One active pulse away from idle, then a gap
    task pulse(input int w, input int g);
        pinOut <= ~idleLevel;
        repeat (w) @(posedge core_clk);
        pinOut <= idleLevel;
        repeat (g) @(posedge core_clk);
    endtask
endmodule

/* File: verif/pwtc_timer_asserts.sv */
`timescale 1ns/100ps
// Output timing checks
module pwtc_timer_asserts (
    input wire logic       core_clk,
    input wire logic       reset,
    input wire logic       regRead,
    input wire logic [7:0] regReadData,
    input wire logic       powerDown,
    input wire logic       timerIrq,
    input wire logic       wakeUp,
    input wire logic       overflowPulse
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    a_read_idle: assert property (!$past(regRead) |-> regReadData == 8'h00)
        else $error("read data outside slot");
    a_irq_from_ovf: assert property (timerIrq |-> overflowPulse)
        else $error("irq without overflow");
    a_wake_from_ovf: assert property (wakeUp |-> overflowPulse)
        else $error("wake without overflow");
    a_wake_when_down: assert property (overflowPulse && powerDown && $past(powerDown)
        && $past(powerDown, 2) |-> wakeUp)
        else $error("no wake in power-down");
    a_wake_only_down: assert property (wakeUp |-> powerDown || $past(powerDown))
        else $error("wake while awake");
    a_ovf_spacing: assert property (overflowPulse |=> !overflowPulse [*3])
        else $error("overflows too close");
    a_irq_spacing: assert property (timerIrq |=> !timerIrq [*3])
        else $error("irq pulses too close");
    a_quiet_release: assert property ($fell(reset) |-> !overflowPulse && !timerIrq
        && !wakeUp)
        else $error("output after reset");
endmodule
bind pwtc_timer pwtc_timer_asserts u_chk (.core_clk(core_clk), .reset(reset),
    .regRead(regRead), .regReadData(regReadData), .powerDown(powerDown),
    .timerIrq(timerIrq), .wakeUp(wakeUp), .overflowPulse(overflowPulse));

/* File: verif/pwtc_timer_tb.sv */
`timescale 1ns/100ps
// Self-checking bench for the pulse width timer
module pwtc_timer_tb;
    logic        core_clk;
    logic        reset;
    logic [3:0]  regAddr;
    logic [7:0]  regWriteData;
    logic        regWrite;
    logic        regRead;
    logic [7:0]  regReadData;
    logic        ch0InputPin;
    logic        powerDown;
    logic        timerIrq;
    logic        wakeUp;
    logic        overflowPulse;
    int          fail_count;
    int          cmp_count;
    int          cycleCount;
    int          irqCount;
    int          wakeCount;
    logic [7:0]  rdData;
    logic [15:0] cnt;
    logic [15:0] cntAgain;
    logic [12:0] tbl [0:8];

    pwtc_timer u_pwtc_timer (.core_clk(core_clk), .reset(reset), .regAddr(regAddr),
        .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
        .regReadData(regReadData), .ch0InputPin(ch0InputPin), .powerDown(powerDown),
        .timerIrq(timerIrq), .wakeUp(wakeUp), .overflowPulse(overflowPulse));
    pwtc_pin_source u_pwtc_pin_source (.core_clk(core_clk), .pinOut(ch0InputPin));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Pulse tallies and hang guard
    always @(posedge core_clk) begin
        cycleCount <= cycleCount + 1;
        if (timerIrq === 1'b1) irqCount <= irqCount + 1;
        if (wakeUp === 1'b1) wakeCount <= wakeCount + 1;
        if (cycleCount == 20000) begin
            fail_count = fail_count + 1;
            end_of_test();
        end
    end
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
        @(posedge core_clk);
    endtask
    task rd(input logic [3:0] a, output logic [7:0] d);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        @(negedge core_clk);
        d = regReadData;
        @(posedge core_clk);
    endtask
    // Zero preload, arm, one 40-clock pulse, read high then low
    task meas(input logic [7:0] c, input logic idle, output logic [15:0] n);
        wr(4'h0, c);
        wr(4'h1, 8'h00);
        wr(4'h2, 8'h00);
        u_pwtc_pin_source.setIdle(idle);
        wr(4'h0, c | 8'h10);
        u_pwtc_pin_source.pulse(40, 20);
        rd(4'h2, n[15:8]);
        rd(4'h1, n[7:0]);
    endtask
    task end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        reset = 1'b1;
        regAddr = 4'h0;
        regWriteData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        powerDown = 1'b0;
        tbl = '{13'h10C0, 13'h1134, 13'h1212, 13'h0212, 13'h0134, 13'h00C0, 13'h0500,
                13'h1301, 13'h0301};
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        // Table rows: write or read-and-compare
        foreach (tbl[i]) begin
            if (tbl[i][12]) wr(tbl[i][11:8], tbl[i][7:0]);
            else begin
                rd(tbl[i][11:8], rdData);
                chk("reg", {8'h00, rdData}, {8'h00, tbl[i][7:0]});
            end
        end
        // Single shot in both edge senses
        for (int e = 0; e < 2; e++) begin
            meas(e ? 8'hC8 : 8'hC0, ~e[0], cnt);
            chk("width", {15'h0000, cnt >= 16'h0009 && cnt <= 16'h000B}, 16'h0001);
            rd(4'h0, rdData);
            chk("ctrl", {8'h00, rdData}, {8'h00, e ? 8'hC8 : 8'hC0});
        end
        // Disarmed pin activity
        u_pwtc_pin_source.pulse(40, 20);
        rd(4'h2, cntAgain[15:8]);
        rd(4'h1, cntAgain[7:0]);
        chk("hold", cntAgain, cnt);
        // Timer mode counts one tick in four clocks
        wr(4'h0, 8'h80);
        wr(4'h1, 8'h00);
        wr(4'h2, 8'h00);
        wr(4'h0, 8'h90);
        repeat (40) @(posedge core_clk);
        wr(4'h0, 8'h80);
        rd(4'h2, cntAgain[15:8]);
        rd(4'h1, cntAgain[7:0]);
        chk("tmode", {15'h0000, cntAgain >= 16'h000A && cntAgain <= 16'h000B}, 16'h0001);
        // Overflow with interrupt enabled
        wr(4'h0, 8'hC0);
        u_pwtc_pin_source.setIdle(1'b1);
        wr(4'h1, 8'hF8);
        wr(4'h2, 8'hFF);
        wr(4'h3, 8'h01);
        wr(4'h0, 8'hD0);
        u_pwtc_pin_source.pulse(48, 20);
        rd(4'h3, rdData);
        chk("irq", irqCount[15:0], 16'h0001);
        chk("flag", {8'h00, rdData}, 16'h0003);
        // Event counting in power-down, interrupt masked
        wr(4'h3, 8'h00);
        wr(4'h0, 8'h40);
        u_pwtc_pin_source.setIdle(1'b0);
        wr(4'h1, 8'hFE);
        wr(4'h2, 8'hFF);
        powerDown <= 1'b1;
        wr(4'h0, 8'h50);
        repeat (3) u_pwtc_pin_source.pulse(12, 12);
        chk("wake", wakeCount[15:0], 16'h0001);
        chk("masked", irqCount[15:0], 16'h0001);
        rd(4'h0, rdData);
        chk("event", {8'h00, rdData}, 16'h0050);
        end_of_test();
    end
endmodule
